// ==== src/boot_consts.svh ====
// Constants shared by both ends of the boot stream link.
`ifndef BOOT_CONSTS_SVH
`define BOOT_CONSTS_SVH
// ----------------------------------------------------------------------
// Stream keys and layout
// ----------------------------------------------------------------------
`define KEY_WIDE 16'h10AA
`define KEY_BYTE 16'h08AA
`define RSVD_WORDS 16'h0008
`define END_MARK 16'h0000
// ----------------------------------------------------------------------
// Boot source selection pins
// ----------------------------------------------------------------------
`define SEL_PARALLEL 2'h0
`define SEL_SERIAL 2'h1
`define SEL_SYNC_SERIAL 2'h2
`define SEL_FLASH 2'h3
`define PULLUP_ALL 3'h7
// ----------------------------------------------------------------------
// Security password words
// ----------------------------------------------------------------------
`define PWD_WORDS 4'h8
`define PWD_ERASED 16'hFFFF
`endif

// ==== src/boot_pkg.sv ====
// Types shared by both ends of the boot stream link.
package boot_pkg;
    // Loader sequence states, one-hot.
    typedef enum logic [14:0] {
        S_INIT = 15'h0001,
        S_PWD = 15'h0002,
        S_SELECT = 15'h0004,
        S_KEY1 = 15'h0008,
        S_KEY2 = 15'h0010,
        S_RSVD = 15'h0020,
        S_ENTRY_HI = 15'h0040,
        S_ENTRY_LO = 15'h0080,
        S_BSIZE = 15'h0100,
        S_ADDR_HI = 15'h0200,
        S_ADDR_LO = 15'h0400,
        S_DATA = 15'h0800,
        S_WDOG = 15'h1000,
        S_EXIT = 15'h2000,
        S_RUN = 15'h4000
    } load_state_e;
    // Host sender states, one-hot.
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_LOW = 4'h2,
        H_HIGH = 4'h4,
        H_DONE = 4'h8
    } host_state_e;
endpackage : boot_pkg

// ==== src/boot_link_if.sv ====
// Link between the external host and the boot stream loader.
`timescale 1ns/1ps
`default_nettype none
interface boot_link_if;
    logic [15:0] data; // Stream value; low byte only in byte-pair mode.
    logic valid; // Host offers a value.
    logic ready; // Loader can take a value.
    logic mode_trst; // Test-reset pin level.
    logic [1:0] mode_sel; // Two mode-select pin levels.
    logic [2:0] pullup_en; // Loader enables pull-ups on the mode pins.
    modport device (input data, valid, mode_trst, mode_sel,
                    output ready, pullup_en);
    modport host (output data, valid, mode_trst, mode_sel,
                  input ready, pullup_en);
endinterface : boot_link_if
`default_nettype wire

// ==== src/boot_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module boot_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Filling side.
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    // Draining side.
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
    logic [AW-1:0] wr_q; // Write pointer.
    logic [AW-1:0] rd_q; // Read pointer.
    logic [AW:0] cnt_q; // Words held.
    logic push;
    logic pop;

    // Full and empty come straight from the count.
    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data = mem[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // Storage is written without reset; only the pointers and the count need one.
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_q] <= i_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : boot_fifo
`default_nettype wire

// ==== src/boot_stream_loader.sv ====
// Device end: start-up sequence, boot source choice and stream loader.
`timescale 1ns/1ps
`default_nettype none
`include "boot_consts.svh"
// Operation
// - First value equal to wide key selects words.
// - Else pair two values, compare byte key.
// - Abort on unknown key or disallowed width.
// - Single-width source only checks its own key.
// - Byte pairs arrive low byte then high.
// - Key, eight reserved words, then entry address.
// - Block: size, address upper then lower, data.
// - Data words go to consecutive addresses.
// - Block size zero ends the stream.
// - Set mode, then dummy password read unlocks; the code starts both in the same cycle.
// - Then boot source selection returns entry address.
// - Restore registers, then jump to entry.
// - Mode from test-reset and two select pins.
// - Select pins sampled later, not at reset.
// - Board holds select pins until sampled.
// - Pull-ups on select pins enabled from reset.
// - Board should strap select pins weakly.
// - Disable watchdog before any stream loader.
// - After load, enable watchdog and clear it.
// - No loader means watchdog left alone.
// - Long values send upper word first.
// - Entry address top byte sent as zero.
module boot_stream_loader #(
    parameter logic [31:0] FLASH_ENTRY = 32'h0000_1000,
    parameter logic [31:0] EMU_ENTRY = 32'h0000_2000,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Link to the host.
    boot_link_if.device link,
    // Password word read port.
    output logic [3:0] o_pwd_index,
    output logic o_pwd_rd,
    input wire logic [15:0] i_pwd_data,
    // Memory write port.
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [15:0] o_mem_data,
    // Status and control toward the rest of the chip.
    output logic o_cpu_mode_set,
    output logic o_secure_unlocked,
    output logic [1:0] o_boot_source,
    output logic o_loader_active,
    output logic o_wdog_enable,
    output logic o_wdog_clear,
    output logic o_reg_restore,
    output logic o_jump,
    output logic [31:0] o_entry_address,
    output logic o_abort,
    output boot_pkg::load_state_e o_state
);
    import boot_pkg::*;
    // ------------------------------------------------------------------
    // Get-word path
    // ------------------------------------------------------------------
    logic [15:0] f_data; // Raw value at the FIFO head.
    logic f_valid; // FIFO holds a value.
    logic fetch; // Sequence is waiting for a stream value.
    logic pop; // A raw value is taken this cycle.
    logic word_ok; // A full 16-bit stream word is complete.
    logic [15:0] word; // The completed stream word.
    logic byte_q; // Byte-pair mode chosen by the key.
    logic lo_have_q; // Low byte of a pair is held.
    logic [7:0] lo_q; // The held low byte.
    logic [15:0] first_q; // First header value.
    logic allow_wide_q; // Source permits word mode.
    logic allow_byte_q; // Source permits byte-pair mode.
    logic [15:0] cnt_q; // Reserved or data words still to come.
    logic [15:0] upper_word_q; // Upper word of a long value.
    logic pwd_ok_q; // All password words read as erased so far.
    load_state_e state_q; // Boot sequence state.
    // The FIFO decouples the host from the sequence, which may stall.
    boot_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clock(i_clock), .i_rst(i_rst),
        .i_data(link.data), .i_valid(link.valid),
        .o_ready(link.ready), .o_data(f_data),
        .o_valid(f_valid), .i_ready(fetch)
    );
    // Every loading state draws from the same path.
    assign fetch = state_q inside {S_KEY1, S_KEY2, S_RSVD, S_ENTRY_HI,
        S_ENTRY_LO, S_BSIZE, S_ADDR_HI, S_ADDR_LO, S_DATA};
    assign pop = fetch && f_valid;
    // In byte-pair mode the second byte is the high one.
    assign word_ok = pop && (!byte_q || lo_have_q);
    assign word = byte_q ? {f_data[7:0], lo_q} : f_data;
    // Pull-ups stay on from reset; nothing ever turns them off.
    assign link.pullup_en = `PULLUP_ALL;
    // Byte pairing tracks which half of a word is next.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lo_have_q <= 1'b0;
            lo_q <= 8'h00;
        end else if (pop && byte_q) begin
            lo_have_q <= !lo_have_q;
            if (!lo_have_q) begin
                lo_q <= f_data[7:0];
            end
        end
    end
    // ------------------------------------------------------------------
    // Boot sequence
    // ------------------------------------------------------------------
    // One pass from reset to the jump; the run state is terminal.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= S_INIT;
            byte_q <= 1'b0;
            first_q <= 16'h0000;
            allow_wide_q <= 1'b0;
            allow_byte_q <= 1'b0;
            cnt_q <= 16'h0000;
            upper_word_q <= 16'h0000;
            pwd_ok_q <= 1'b1;
            o_pwd_index <= 4'h0;
            o_pwd_rd <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_data <= 16'h0000;
            o_cpu_mode_set <= 1'b0;
            o_secure_unlocked <= 1'b0;
            o_boot_source <= `SEL_FLASH;
            o_loader_active <= 1'b0;
            o_wdog_enable <= 1'b1;
            o_wdog_clear <= 1'b0;
            o_reg_restore <= 1'b0;
            o_jump <= 1'b0;
            o_entry_address <= 32'h0000_0000;
            o_abort <= 1'b0;
        end else begin
            o_mem_we <= 1'b0;
            o_wdog_clear <= 1'b0;
            o_reg_restore <= 1'b0;
            o_jump <= 1'b0;
            o_cpu_mode_set <= 1'b0;
            case (state_q)
                S_INIT: begin
                    // Processor mode and the password read start in the same cycle.
                    o_cpu_mode_set <= 1'b1;
                    o_pwd_rd <= 1'b1;
                    o_pwd_index <= 4'h0;
                    state_q <= S_PWD;
                end
                S_PWD: begin
                    // Data is valid for the index shown this cycle.
                    if (o_pwd_index == `PWD_WORDS - 4'h1) begin
                        o_pwd_rd <= 1'b0;
                        o_secure_unlocked <= pwd_ok_q &&
                            (i_pwd_data == `PWD_ERASED);
                        state_q <= S_SELECT;
                    end else begin
                        pwd_ok_q <= pwd_ok_q && (i_pwd_data == `PWD_ERASED);
                        o_pwd_index <= o_pwd_index + 4'h1;
                    end
                end
                S_SELECT: begin
                    // Pins are first looked at here, long after reset.
                    o_boot_source <= link.mode_sel;
                    if (link.mode_trst) begin
                        o_entry_address <= EMU_ENTRY;
                        state_q <= S_EXIT;
                    end else if (link.mode_sel == `SEL_FLASH) begin
                        o_entry_address <= FLASH_ENTRY;
                        state_q <= S_EXIT;
                    end else begin
                        o_wdog_enable <= 1'b0;
                        o_loader_active <= 1'b1;
                        allow_wide_q <= (link.mode_sel == `SEL_PARALLEL);
                        allow_byte_q <= 1'b1;
                        state_q <= S_KEY1;
                    end
                end
                S_KEY1: begin
                    if (pop) begin
                        first_q <= f_data;
                        if (allow_wide_q && f_data == `KEY_WIDE) begin
                            cnt_q <= `RSVD_WORDS;
                            state_q <= S_RSVD;
                        end else if (allow_byte_q) begin
                            state_q <= S_KEY2;
                        end else begin
                            o_abort <= 1'b1;
                            o_entry_address <= FLASH_ENTRY;
                            state_q <= S_WDOG;
                        end
                    end
                end
                S_KEY2: begin
                    if (pop) begin
                        if ({f_data[7:0], first_q[7:0]} == `KEY_BYTE) begin
                            byte_q <= 1'b1;
                            cnt_q <= `RSVD_WORDS;
                            state_q <= S_RSVD;
                        end else begin
                            o_abort <= 1'b1;
                            o_entry_address <= FLASH_ENTRY;
                            state_q <= S_WDOG;
                        end
                    end
                end
                S_RSVD: begin
                    if (word_ok) begin
                        cnt_q <= cnt_q - 16'h0001;
                        state_q <= (cnt_q == 16'h0001) ? S_ENTRY_HI : S_RSVD;
                    end
                end
                S_ENTRY_HI, S_ADDR_HI: begin
                    // The entry top byte is trusted to be zero.
                    if (word_ok) begin
                        upper_word_q <= word;
                        state_q <= (state_q == S_ADDR_HI) ? S_ADDR_LO :
                                   S_ENTRY_LO;
                    end
                end
                S_ENTRY_LO: begin
                    if (word_ok) begin
                        o_entry_address <= {upper_word_q, word};
                        state_q <= S_BSIZE;
                    end
                end
                S_BSIZE: begin
                    if (word_ok) begin
                        cnt_q <= word;
                        state_q <= (word == `END_MARK) ? S_WDOG : S_ADDR_HI;
                    end
                end
                S_ADDR_LO: begin
                    if (word_ok) begin
                        // Pre-decrement so the first write lands on it.
                        o_mem_addr <= {upper_word_q, word} - 32'h1;
                        state_q <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (word_ok) begin
                        o_mem_we <= 1'b1;
                        o_mem_addr <= o_mem_addr + 32'h1;
                        o_mem_data <= word;
                        cnt_q <= cnt_q - 16'h0001;
                        state_q <= (cnt_q == 16'h0001) ? S_BSIZE : S_DATA;
                    end
                end
                S_WDOG: begin
                    // Reached only after a loader ran, even an aborted one.
                    o_wdog_enable <= 1'b1;
                    o_wdog_clear <= 1'b1;
                    o_loader_active <= 1'b0;
                    state_q <= S_EXIT;
                end
                S_EXIT: begin
                    o_reg_restore <= 1'b1;
                    state_q <= S_RUN;
                end
                S_RUN: begin
                    // Jump pulses once, one cycle after the restore.
                    o_jump <= o_reg_restore;
                end
                default: begin
                    state_q <= S_INIT;
                end
            endcase
        end
    end
    assign o_state = state_q;
endmodule : boot_stream_loader
`default_nettype wire

// ==== src/boot_stream_host.sv ====
// Host end: holds the mode pins and sends stream words to the loader.
`timescale 1ns/1ps
`default_nettype none
`include "boot_consts.svh"
module boot_stream_host (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Link to the loader.
    boot_link_if.host link,
    // Mode strap levels to present.
    input wire logic i_mode_trst,
    input wire logic [1:0] i_mode_sel,
    // Stream words from the user.
    input wire logic [15:0] i_word,
    input wire logic i_word_valid,
    input wire logic i_word_last,
    input wire logic i_byte_mode,
    output logic o_word_ready,
    output logic o_finished
);
    import boot_pkg::*;

    host_state_e state_q; // Sender state.
    logic [15:0] word_q; // Word being sent.
    logic last_q; // Word being sent ends the stream.
    logic [15:0] data_q; // Value on the link.
    logic valid_q; // Value offered.
    logic trst_q; // Held test-reset level.
    logic [1:0] sel_q; // Held select levels.
    logic take; // Loader takes the offered value.

    assign take = valid_q && link.ready;
    assign link.data = data_q;
    assign link.valid = valid_q;
    assign link.mode_trst = trst_q;
    assign link.mode_sel = sel_q;

    // Straps are driven every cycle so they stay put while sampled;
    // the board side should make them weak.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            trst_q <= 1'b0;
            sel_q <= `SEL_FLASH;
        end else begin
            trst_q <= i_mode_trst;
            sel_q <= i_mode_sel;
        end
    end

    // Words go out whole, or as low byte then high byte.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= H_IDLE;
            word_q <= 16'h0000;
            last_q <= 1'b0;
            data_q <= 16'h0000;
            valid_q <= 1'b0;
            o_word_ready <= 1'b1;
            o_finished <= 1'b0;
        end else begin
            case (state_q)
                H_IDLE: begin
                    if (i_word_valid) begin
                        word_q <= i_word;
                        last_q <= i_word_last;
                        valid_q <= 1'b1;
                        o_word_ready <= 1'b0;
                        if (i_byte_mode) begin
                            data_q <= {8'h00, i_word[7:0]};
                            state_q <= H_LOW;
                        end else begin
                            data_q <= i_word;
                            state_q <= H_HIGH;
                        end
                    end
                end
                H_LOW: begin
                    if (take) begin
                        data_q <= {8'h00, word_q[15:8]};
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (take) begin
                        valid_q <= 1'b0;
                        if (last_q) begin
                            o_finished <= 1'b1;
                            state_q <= H_DONE;
                        end else begin
                            o_word_ready <= 1'b1;
                            state_q <= H_IDLE;
                        end
                    end
                end
                H_DONE: begin
                    // Nothing more is sent after the end mark.
                    valid_q <= 1'b0;
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end
endmodule : boot_stream_host
`default_nettype wire

// ==== bench/boot_stream_loader_assertions.sv ====
// Link checks between the boot stream host and loader.
`timescale 1ns/1ps
`default_nettype none
module boot_stream_loader_assertions (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Link signals.
    input wire logic [15:0] data,
    input wire logic valid,
    input wire logic ready,
    input wire logic mode_trst,
    input wire logic [1:0] mode_sel,
    input wire logic [2:0] pullup_en
);
    // Cycles since reset release; the straps settle in the first few.
    logic [5:0] cyc_q;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cyc_q <= 6'h00;
        end else if (cyc_q != 6'h3F) begin
            cyc_q <= cyc_q + 6'h01;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_pullups_on: assert property (pullup_en == 3'h7)
        else $error("mode pin pull-ups off");
    chk_valid_held: assert property (valid && !ready |=> valid)
        else $error("offer dropped before take");
    chk_data_held: assert property (valid && !ready
        |=> $stable(data)) else $error("offered value changed before take");
    chk_ready_start: assert property ($past(i_rst) |-> ready)
        else $error("buffer not ready after reset");
    chk_full_cause: assert property ($fell(ready) |-> $past(valid))
        else $error("ready fell without a push");
    chk_sel_held: assert property (cyc_q >= 6'h03 && cyc_q <= 6'h1E
        |-> $stable(mode_sel)) else $error("select straps moved");
    chk_trst_held: assert property (cyc_q >= 6'h03
        && cyc_q <= 6'h1E |-> $stable(mode_trst))
        else $error("test-reset strap moved");
    chk_stall_bounded: assert property (valid && !ready
        |-> ##[1:64] ready) else $error("loader stopped draining");
endmodule : boot_stream_loader_assertions
`default_nettype wire

// ==== bench/boot_stream_loader_tb_top.sv ====
// Bench joining host and loader, checked against a stream model.
`timescale 1ns/1ps
`default_nettype none
module boot_stream_loader_tb_top;
    import boot_pkg::*;
    localparam logic [31:0] F = 32'h0000_1000;
    localparam logic [31:0] E = 32'h0000_2000;
    logic i_clock, i_rst, trst, wvalid, wlast, bmode, wready, fin, prd;
    logic we, mset, unl, act, wden, wdclr, rstr, jump, abort;
    logic [1:0] sel, src;
    logic [3:0] pidx;
    logic [15:0] word, mdata;
    logic [15:0] pwd [8];
    logic [31:0] maddr, entry, ent_x;
    load_state_e state;
    int n_fail, tests_run, seed, n_clr, n_rst, n_mode;
    logic [47:0] exp_q [$]; // Expected {address, data} writes.
    logic [15:0] st [$]; // Stream words for the host.
    logic [15:0] seen [$]; // Values taken on the link.
    boot_link_if link();
    boot_stream_loader #(.FLASH_ENTRY(F), .EMU_ENTRY(E)) u_boot_stream_loader (
        .i_clock(i_clock), .i_rst(i_rst), .link(link), .o_pwd_index(pidx),
        .o_pwd_rd(prd), .i_pwd_data(pwd[pidx[2:0]]), .o_mem_we(we),
        .o_mem_addr(maddr), .o_mem_data(mdata), .o_cpu_mode_set(mset),
        .o_secure_unlocked(unl), .o_boot_source(src), .o_loader_active(act),
        .o_wdog_enable(wden), .o_wdog_clear(wdclr), .o_reg_restore(rstr),
        .o_jump(jump), .o_entry_address(entry), .o_abort(abort),
        .o_state(state));
    boot_stream_host u_boot_stream_host (.i_clock(i_clock), .i_rst(i_rst),
        .link(link), .i_mode_trst(trst), .i_mode_sel(sel), .i_word(word),
        .i_word_valid(wvalid), .i_word_last(wlast), .i_byte_mode(bmode),
        .o_word_ready(wready), .o_finished(fin));
    boot_stream_loader_assertions u_chk (.i_clock(i_clock), .i_rst(i_rst),
        .data(link.data), .valid(link.valid), .ready(link.ready),
        .mode_trst(link.mode_trst), .mode_sel(link.mode_sel),
        .pullup_en(link.pullup_en));
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // Monitor: pulses are counted, writes matched against the model.
    always @(posedge i_clock) begin
        if (we === 1'b1) begin
            // A write the model does not expect compares against all ones.
            check({maddr, mdata},
                  exp_q.size() ? exp_q.pop_front() : '1);
        end
        if (act === 1'b1) check(wden, 1'b0);
        if (link.valid === 1'b1 && link.ready === 1'b1) begin
            seen.push_back(link.data);
        end
        n_clr += wdclr;
        n_rst += rstr;
        n_mode += mset;
    end
    // Key, reserved words, entry, two random blocks, end mark.
    task automatic mk(input logic [15:0] key);
        logic [31:0] a;
        int sz;
        ent_x = {8'h00, 24'($random(seed))};
        st = {key};
        repeat (8) st.push_back(16'($random(seed)));
        st.push_back(ent_x[31:16]);
        st.push_back(ent_x[15:0]);
        for (int b = 0; b < 2; b++) begin
            sz = b + 1 + ($random(seed) & 3);
            a = $random(seed);
            st.push_back(16'(sz));
            st.push_back(a[31:16]);
            st.push_back(a[15:0]);
            for (int k = 0; k < sz; k++) begin
                st.push_back(16'($random(seed)));
                exp_q.push_back({a + 32'(k), st[$]});
            end
        end
        st.push_back(16'h0000);
    endtask : mk
    // One boot: reset with straps, send the stream, judge at the jump.
    task automatic run(input logic t, input logic [1:0] s, input logic bm,
                       input logic [31:0] ee, input int ld, input logic ab);
        int n;
        i_rst = 1'b1;
        trst = t;
        sel = s;
        bmode = bm;
        repeat (10) @(posedge i_clock);
        #1 i_rst = 1'b0;
        {n_clr, n_rst, n_mode} = 0;
        seen = {};
        foreach (st[i]) begin
            for (n = 0; wready !== 1'b1 && n < 300; n++) begin
                @(posedge i_clock);
                #1;
            end
            if (n == 300) begin n_fail++; stop_test(); end
            word = st[i];
            wvalid = 1'b1;
            wlast = (i == st.size() - 1);
            @(posedge i_clock);
            #1 wvalid = 1'b0;
        end
        for (n = 0; jump !== 1'b1 && n < 1000; n++) begin
            @(posedge i_clock);
            #1;
        end
        if (n == 1000) begin n_fail++; stop_test(); end
        check(entry, ee);
        check(abort, ab);
        check(wden, 1'b1);
        check(n_clr, ld);
        check({16'(n_rst), 32'(n_mode)}, {16'd1, 32'd1});
        check({state, prd, act, pidx}, {S_RUN, 2'b00, 4'h7});
        check(src, s);
        check(exp_q.size(), 0);
        check(unl, pwd.and() == 16'hFFFF);
        if (st.size() > 0) check(fin, 1'b1);
        if (bm) begin
            check({seen[0], seen[1]},
                  {8'h00, st[0][7:0], 8'h00, st[0][15:8]});
        end
        exp_q = {};
    endtask : run
    initial begin
        seed = 6;
        {n_fail, tests_run} = 0;
        {i_rst, trst, sel, word, wvalid, wlast, bmode} = '0;
        i_rst = 1'b1;
        foreach (pwd[i]) pwd[i] = 16'hFFFF;
        mk(16'h10AA);
        run(1'b0, 2'h0, 1'b0, ent_x, 1, 1'b0);
        pwd[3] = 16'h0000;
        mk(16'h08AA);
        run(1'b0, 2'h0, 1'b1, ent_x, 1, 1'b0);
        mk(16'h08AA);
        run(1'b0, 2'h2, 1'b1, ent_x, 1, 1'b0);
        st = {16'h10AA};
        run(1'b0, 2'h1, 1'b1, F, 1, 1'b1);
        st = {16'h1234, 16'h5678};
        run(1'b0, 2'h0, 1'b0, F, 1, 1'b1);
        st = {};
        run(1'b0, 2'h3, 1'b0, F, 0, 1'b0);
        run(1'b1, 2'h0, 1'b0, E, 0, 1'b0);
        stop_test();
    end
endmodule : boot_stream_loader_tb_top
`default_nettype wire
